/* File: ckb_pkg.sv */
// Package with constants, encodings and carrier types of the classifier key builder.
package ckb_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] PORT_OFS      = 8'h04;
  localparam logic [7:0] CUST1_OFS     = 8'h08;
  localparam logic [7:0] CUST2_OFS     = 8'h0c;
  localparam logic [7:0] CUST3_OFS     = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam int         ADDR_LSB      = 2;

  // Field positions in the control register.
  localparam int CTRL_DEFSEL_POS   = 0;  // Two bits: default link index select.
  localparam int CTRL_USECL_POS    = 2;  // Two bits: classified outer tag, per lookup.
  localparam int CTRL_FMT0_POS     = 4;  // Two bits: key format of the first lookup.
  localparam int CTRL_FMT1_POS     = 6;  // Two bits: key format of the second lookup.
  // Field positions in the port register.
  localparam int PORT_LPORT_POS    = 0;  // Six bits: logical port number.
  localparam int PORT_MASQ_POS     = 8;  // Six bits: masqueraded port number.

  // Values after reset.
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] PORT_RST  = 32'h0000_0000;
  localparam logic [15:0] CUST_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // --------------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------------
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88a8;

  localparam logic [2:0] PROTO_NONE  = 3'h0;
  localparam logic [2:0] PROTO_CTAG  = 3'h1;
  localparam logic [2:0] PROTO_STAG  = 3'h4;
  localparam logic [2:0] PROTO_CUST1 = 3'h5;
  localparam logic [2:0] PROTO_CUST2 = 3'h6;
  localparam logic [2:0] PROTO_CUST3 = 3'h7;

  // Two-slot type selector codes; code 2 is reserved and never produced.
  localparam logic [1:0] TYPE_TRI_TAG     = 2'h0;
  localparam logic [1:0] TYPE_DBL_LABEL   = 2'h1;
  localparam logic [1:0] TYPE_IDX_TRI_TAG = 2'h3;

  // Key formats selectable per lookup.
  typedef enum logic [1:0] {
    CKB_FMT_SGL_LABEL = 2'h0,
    CKB_FMT_TRI_TAG   = 2'h1,
    CKB_FMT_DBL_LABEL = 2'h2,
    CKB_FMT_IDX_TRI   = 2'h3
  } ckb_fmt_t;

  // Default link index selections.
  localparam logic [1:0] DEFSEL_ZERO  = 2'h0;
  localparam logic [1:0] DEFSEL_LPORT = 2'h1;
  localparam logic [1:0] DEFSEL_MASQ  = 2'h2;

  // Next index control codes carried by the preceding action.
  localparam logic [1:0] NXT_USE_DEFAULT = 2'h0;
  localparam logic [1:0] NXT_REPLACE     = 2'h1;
  localparam logic [1:0] NXT_ADD         = 2'h2;
  localparam logic [1:0] NXT_KEEP        = 2'h3;

  localparam int KEY_W = 64;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        outer_tagged;
    logic [15:0] outer_tpid;
    logic [2:0]  outer_priority;
    logic        outer_drop_eligible;
    logic [11:0] outer_vlan_id;
    logic        second_tagged;
    logic [15:0] second_tpid;
  } ckb_tags_t;

  typedef struct packed {
    logic [19:0] label;
    logic [2:0]  tc;
    logic        bottom_of_stack;
    logic [7:0]  ttl;
  } ckb_lse_t;

  typedef struct packed {
    logic [2:0]  priority_cl;
    logic        drop_eligible_cl;
    logic [11:0] vlan_id_cl;
  } ckb_cl_tci_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  next_index_control;
    logic [11:0] next_index_value;
  } ckb_action_t;

  typedef struct packed {
    logic        valid;
    logic        two_slot;
    logic [KEY_W-1:0] data;
  } ckb_key_t;

endpackage

/* File: ckb_key_builder.sv */
// Classifier key builder with its APB register file.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps

// What this block does
// - The one-slot label key has no type selector field.
// - Lookup-order flag is one for the first lookup, zero for the second.
// - A 12-bit link index goes into label, double-label and indexed-tag keys.
// - Link index follows the preceding action's index control and value.
// - Without an action, the index is zero, logical port or masqueraded port.
// - Label key holds top label, its bottom-of-stack bit and expiry flag.
// - Expiry flag is one when the top entry's TTL is at most one.
// - Two-slot keys start with type: 0 tri-tag, 1 double-label, 3 indexed.
// - Each two-slot format has its own distinct type code.
// - Triple-tag key carries the six-bit configured logical ingress port.
// - Outer tag code: 0 untagged, 1 C-tag, 4 S-tag, 5 to 7 custom.
// - Second tag code uses the same codes; zero means no second tag.
// - Outer priority, drop-eligible and VLAN come from frame or classified values.
// - Untagged frames get outer VLAN identifier zero in the key, unless the lookup uses classified values.
module ckb_key_builder (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 req_valid,
  input  wire logic                 req_second,
  input  wire ckb_pkg::ckb_tags_t   req_tags,
  input  wire ckb_pkg::ckb_lse_t    req_lse0,
  input  wire ckb_pkg::ckb_lse_t    req_lse1,
  input  wire ckb_pkg::ckb_cl_tci_t req_cl_tci,
  input  wire ckb_pkg::ckb_action_t req_action,
  output ckb_pkg::ckb_key_t         key_out
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Maps a tag protocol identifier to its three-bit code.
  function automatic logic [2:0] proto_code(
    input logic        present,
    input logic [15:0] tpid,
    input logic [15:0] c1,
    input logic [15:0] c2,
    input logic [15:0] c3
  );
    logic [2:0] code;
    code = ckb_pkg::PROTO_NONE;
    if (present) begin
      if (tpid == ckb_pkg::TPID_CTAG) begin
        code = ckb_pkg::PROTO_CTAG;
      end else if (tpid == ckb_pkg::TPID_STAG) begin
        code = ckb_pkg::PROTO_STAG;
      end else if (tpid == c1) begin
        code = ckb_pkg::PROTO_CUST1;
      end else if (tpid == c2) begin
        code = ckb_pkg::PROTO_CUST2;
      end else if (tpid == c3) begin
        code = ckb_pkg::PROTO_CUST3;
      end
    end
    return code;
  endfunction

  // Sets the expiry flag of a label stack entry.
  function automatic logic ttl_expired(input logic [7:0] ttl);
    return (ttl <= 8'h01);
  endfunction

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] port_q;
  logic [15:0] cust_q [3];
  logic [15:0] key_cnt_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        setup;
  logic        wr_en;
  logic [7:0]  word_addr;
  logic        mapped;

  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pwrite;
  assign word_addr = {paddr[7:ckb_pkg::ADDR_LSB], 2'h0};

  // Decodes whether the addressed word exists.
  always_comb begin
    case (word_addr)
      ckb_pkg::CTRL_OFS, ckb_pkg::PORT_OFS, ckb_pkg::CUST1_OFS,
      ckb_pkg::CUST2_OFS, ckb_pkg::CUST3_OFS, ckb_pkg::STATUS_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Holds the control and port configuration words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ckb_pkg::CTRL_RST;
      port_q <= ckb_pkg::PORT_RST;
    end else if (wr_en) begin
      if (word_addr == ckb_pkg::CTRL_OFS) begin
        ctrl_q <= {24'h000000, pwdata[7:0]};
      end
      if (word_addr == ckb_pkg::PORT_OFS) begin
        port_q <= {18'h00000, pwdata[13:8], 2'h0, pwdata[5:0]};
      end
    end
  end

  // Holds the three custom tag protocol identifiers.
  generate
    for (genvar i = 0; i < 3; i++) begin : g_cust
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cust_q[i] <= ckb_pkg::CUST_RST;
        end else if (wr_en &&
                     word_addr == ckb_pkg::CUST1_OFS + 8'(4 * i)) begin
          cust_q[i] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // Captures read data and error in the setup phase, so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~mapped;
      case (word_addr)
        ckb_pkg::CTRL_OFS:   prdata_q <= ctrl_q;
        ckb_pkg::PORT_OFS:   prdata_q <= port_q;
        ckb_pkg::CUST1_OFS:  prdata_q <= {16'h0000, cust_q[0]};
        ckb_pkg::CUST2_OFS:  prdata_q <= {16'h0000, cust_q[1]};
        ckb_pkg::CUST3_OFS:  prdata_q <= {16'h0000, cust_q[2]};
        ckb_pkg::STATUS_OFS: prdata_q <= {16'h0000, key_cnt_q};
        default:             prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign pready  = psel & penable;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  logic [1:0]  defsel;
  logic [1:0]  use_classified_outer_tag;
  logic [5:0]  port_logical_number;
  logic [5:0]  masq_port_number;
  ckb_pkg::ckb_fmt_t fmt;
  logic        first;

  assign defsel                   = ctrl_q[ckb_pkg::CTRL_DEFSEL_POS +: 2];
  assign use_classified_outer_tag = ctrl_q[ckb_pkg::CTRL_USECL_POS +: 2];
  assign port_logical_number      = port_q[ckb_pkg::PORT_LPORT_POS +: 6];
  assign masq_port_number         = port_q[ckb_pkg::PORT_MASQ_POS +: 6];
  assign first                    = ~req_second;

  // Picks the key format configured for this lookup.
  always_comb begin
    if (req_second) begin
      fmt = ckb_pkg::ckb_fmt_t'(ctrl_q[ckb_pkg::CTRL_FMT1_POS +: 2]);
    end else begin
      fmt = ckb_pkg::ckb_fmt_t'(ctrl_q[ckb_pkg::CTRL_FMT0_POS +: 2]);
    end
  end

  // --------------------------------------------------------------------------
  // Generic link index
  // --------------------------------------------------------------------------
  logic [11:0] default_idx;
  logic [11:0] link_idx;
  logic [11:0] last_idx_q;

  // Chooses the default index when no preceding action supplies one.
  always_comb begin
    case (defsel)
      ckb_pkg::DEFSEL_LPORT: default_idx = {6'h00, port_logical_number};
      ckb_pkg::DEFSEL_MASQ:  default_idx = {6'h00, masq_port_number};
      default:               default_idx = 12'h000;
    endcase
  end

  // Derives the index from the preceding action's control and value.
  always_comb begin
    link_idx = default_idx;
    if (req_action.valid) begin
      case (req_action.next_index_control)
        ckb_pkg::NXT_REPLACE: link_idx = req_action.next_index_value;
        ckb_pkg::NXT_ADD:     link_idx = 12'(default_idx + req_action.next_index_value);
        ckb_pkg::NXT_KEEP:    link_idx = last_idx_q;
        default:              link_idx = default_idx;
      endcase
    end
  end

  // Remembers the index used by the latest key, for the keep control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_idx_q <= 12'h000;
    end else if (req_valid) begin
      last_idx_q <= link_idx;
    end
  end

  // --------------------------------------------------------------------------
  // Tag fields
  // --------------------------------------------------------------------------
  logic        use_cl;
  logic [2:0]  outer_tag_proto_code;
  logic [2:0]  second_tag_proto_code;
  logic [2:0]  outer_priority;
  logic        outer_drop_eligible;
  logic [11:0] outer_vlan_id;
  logic [5:0]  ingress_logical_port;

  assign use_cl = use_classified_outer_tag[req_second];
  assign ingress_logical_port = port_logical_number;
  assign outer_tag_proto_code = proto_code(req_tags.outer_tagged, req_tags.outer_tpid,
                                           cust_q[0], cust_q[1], cust_q[2]);
  assign second_tag_proto_code = proto_code(req_tags.outer_tagged & req_tags.second_tagged,
                                            req_tags.second_tpid,
                                            cust_q[0], cust_q[1], cust_q[2]);

  // Selects frame or classified outer tag values for this lookup.
  always_comb begin
    if (use_cl) begin
      outer_priority      = req_cl_tci.priority_cl;
      outer_drop_eligible = req_cl_tci.drop_eligible_cl;
      outer_vlan_id       = req_cl_tci.vlan_id_cl;
    end else begin
      outer_priority      = req_tags.outer_priority;
      outer_drop_eligible = req_tags.outer_drop_eligible;
      outer_vlan_id       = req_tags.outer_vlan_id;
    end
    if (!req_tags.outer_tagged && !use_cl) begin
      outer_vlan_id = 12'h000;
    end
  end

  // --------------------------------------------------------------------------
  // Key assembly
  // --------------------------------------------------------------------------
  logic [34:0] single_label_key;
  logic [27:0] triple_tag_body;
  logic [60:0] double_label_body;
  logic [29:0] indexed_triple_tag_body;
  logic [1:0]  two_slot_type_sel;
  logic [60:0] two_slot_body;
  logic [ckb_pkg::KEY_W-1:0] key_d;

  // Lays out the one-slot label key, which carries no type selector.
  assign single_label_key = {first, link_idx,
                             req_lse0.label, req_lse0.bottom_of_stack,
                             ttl_expired(req_lse0.ttl)};

  assign triple_tag_body = {ingress_logical_port, outer_tag_proto_code, outer_priority,
                            outer_drop_eligible, outer_vlan_id, second_tag_proto_code};

  assign double_label_body = {link_idx,
                              req_lse0.label, req_lse0.bottom_of_stack,
                              ttl_expired(req_lse0.ttl),
                              req_lse1.label, req_lse1.tc, req_lse1.bottom_of_stack,
                              ttl_expired(req_lse1.ttl), 2'h0};  // Left-aligned body.

  assign indexed_triple_tag_body = {link_idx, outer_tag_proto_code, outer_vlan_id,
                                    second_tag_proto_code};

  // Chooses the distinct type selector and body of the two-slot formats.
  always_comb begin
    case (fmt)
      ckb_pkg::CKB_FMT_TRI_TAG: begin
        two_slot_type_sel = ckb_pkg::TYPE_TRI_TAG;
        two_slot_body     = {triple_tag_body, 33'h0_0000_0000};
      end
      ckb_pkg::CKB_FMT_DBL_LABEL: begin
        two_slot_type_sel = ckb_pkg::TYPE_DBL_LABEL;
        two_slot_body     = double_label_body;
      end
      ckb_pkg::CKB_FMT_IDX_TRI: begin
        two_slot_type_sel = ckb_pkg::TYPE_IDX_TRI_TAG;
        two_slot_body     = {indexed_triple_tag_body, 31'h0000_0000};
      end
      default: begin
        two_slot_type_sel = ckb_pkg::TYPE_TRI_TAG;
        two_slot_body     = 61'h0;
      end
    endcase
  end

  // Left-aligns the selected key in the output word.
  always_comb begin
    if (fmt == ckb_pkg::CKB_FMT_SGL_LABEL) begin
      key_d = {single_label_key, 29'h0000_0000};
    end else begin
      key_d = {two_slot_type_sel, first, two_slot_body};
    end
  end

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  ckb_pkg::ckb_key_t key_q;

  // Registers one key per request and pulses valid for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= '0;
    end else begin
      key_q.valid <= req_valid;
      if (req_valid) begin
        key_q.two_slot <= (fmt != ckb_pkg::CKB_FMT_SGL_LABEL);
        key_q.data     <= key_d;
      end
    end
  end

  // Counts the keys issued, visible in the status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_cnt_q <= ckb_pkg::CNT_RST;
    end else if (req_valid) begin
      key_cnt_q <= key_cnt_q + 16'h0001;
    end
  end

  assign key_out = key_q;

endmodule // ckb_key_builder

/* File: ckb_key_builder_properties.sv */
// Checker of the key builder's key port timing and single-slot layout.
`timescale 1ns/10ps
module ckb_key_builder_properties (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              req_valid,
  input wire logic              req_second,
  input wire ckb_pkg::ckb_lse_t req_lse0,
  input wire ckb_pkg::ckb_key_t key_out
);
  // All checks sample on the rising edge and rest during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_KEY_ONE_CYCLE: assert property (req_valid |=> key_out.valid)
    else $error("Key valid missing one cycle after a request.");
  AST_KEY_NO_EXTRA: assert property (!req_valid |=> !key_out.valid)
    else $error("Key valid without a request.");
  AST_KEY_HOLD: assert property (!$past(req_valid) |-> $stable(key_out.data))
    else $error("Key data changed without a request.");
  AST_SGL_FIRST: assert property (key_out.valid && !key_out.two_slot
    |-> key_out.data[63] == !$past(req_second)) else $error("Bad lookup flag, one slot.");
  AST_TWO_FIRST: assert property (key_out.valid && key_out.two_slot
    |-> key_out.data[61] == !$past(req_second)) else $error("Bad lookup flag, two slot.");
  AST_TYPE_CODE: assert property (key_out.valid && key_out.two_slot
    |-> key_out.data[63:62] != 2'h2) else $error("Reserved type code issued.");
  AST_TTL_EXPIRY: assert property (key_out.valid && !key_out.two_slot
    |-> key_out.data[29] == ($past(req_lse0.ttl) <= 8'h01)) else $error("Bad expiry flag.");
  AST_TOP_LABEL: assert property (key_out.valid && !key_out.two_slot
    |-> key_out.data[50:30] == {$past(req_lse0.label), $past(req_lse0.bottom_of_stack)})
    else $error("Bad top label fields.");
  AST_SGL_NO_TYPE: assert property (key_out.valid && !key_out.two_slot
    |-> key_out.data[28:0] == 29'h0) else $error("One-slot key has stray bits.");
endmodule // ckb_key_builder_properties

bind ckb_key_builder ckb_key_builder_properties ckb_key_builder_properties_i (
  .pclk(pclk), .presetn(presetn), .req_valid(req_valid),
  .req_second(req_second), .req_lse0(req_lse0), .key_out(key_out));

/* File: ckb_key_sink.sv */
// Model of the match table that takes the issued keys.
`timescale 1ns/10ps
module ckb_key_sink (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire ckb_pkg::ckb_key_t key_in,
  output logic [15:0]            seen_cnt_q,
  output ckb_pkg::ckb_key_t      last_key_q
);
  // Each valid pulse is one key; the table never stalls the builder.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_cnt_q <= 16'h0000;
      last_key_q <= '0;
    end else if (key_in.valid) begin
      seen_cnt_q <= seen_cnt_q + 16'h0001;
      last_key_q <= key_in;
    end
  end
endmodule // ckb_key_sink

/* File: ckb_key_builder_tb.sv */
// Self-checking bench of the classifier key builder.
`timescale 1ns/10ps
module ckb_key_builder_tb;
  typedef struct {
    logic [7:0]           ctrl;
    logic                 sec;
    ckb_pkg::ckb_tags_t   tg;
    ckb_pkg::ckb_action_t act;
    logic [7:0]           ttl;
    logic [11:0]          idx;
    logic [2:0]           oc;
    logic [2:0]           sc;
    logic [11:0]          vid;
  } ckb_row_t;
  localparam ckb_pkg::ckb_lse_t    L0 = {20'habcde, 3'h5, 1'b1, 8'h00};
  localparam ckb_pkg::ckb_lse_t    L1 = {20'h12345, 3'h6, 1'b0, 8'h40};
  localparam ckb_pkg::ckb_cl_tci_t CL = {3'h6, 1'b1, 12'h777};
  localparam logic [5:0]           LPORT = 6'h2a;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic                 req_valid, req_second;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [15:0]          sink_cnt;
  ckb_pkg::ckb_tags_t   req_tags;
  ckb_pkg::ckb_lse_t    req_lse0, req_lse1;
  ckb_pkg::ckb_cl_tci_t req_cl_tci;
  ckb_pkg::ckb_action_t req_action;
  ckb_pkg::ckb_key_t    key_out, sink_key;
  ckb_row_t             rows [11];
  ckb_row_t             b;
  int                   fails, total_checks;

  // Free-running bus clock.
  always #12.5 pclk = ~pclk;

  ckb_key_builder ckb_key_builder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .req_second(req_second),
    .req_tags(req_tags), .req_lse0(req_lse0), .req_lse1(req_lse1),
    .req_cl_tci(req_cl_tci), .req_action(req_action), .key_out(key_out));
  ckb_key_sink ckb_key_sink_i (.pclk(pclk), .presetn(presetn), .key_in(key_out),
    .seen_cnt_q(sink_cnt), .last_key_q(sink_key));

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compares a register word or flag.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a whole key.
  task automatic chk_key(input ckb_pkg::ckb_key_t got, input ckb_pkg::ckb_key_t exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; it starts and ends just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Frame tags with fixed priority, drop-eligible and VLAN values.
  function automatic ckb_pkg::ckb_tags_t tg(input logic [15:0] o, input logic [15:0] s);
    tg = {o != 16'h0, o, 3'h3, 1'b0, 12'h123, s != 16'h0, s};
  endfunction

  // Lays out the expected key from the row's settings and field values.
  function automatic ckb_pkg::ckb_key_t exp_key(input ckb_row_t r);
    ckb_pkg::ckb_key_t k;
    logic [1:0]        f;
    logic              fs, u, d, xp;
    logic [2:0]        p;
    f = r.sec ? r.ctrl[7:6] : r.ctrl[5:4];
    fs = !r.sec;
    u = r.ctrl[2 + r.sec];
    p = u ? CL.priority_cl : r.tg.outer_priority;
    d = u ? CL.drop_eligible_cl : r.tg.outer_drop_eligible;
    xp = r.ttl <= 8'h01;
    k.valid = 1'b1;
    k.two_slot = f != 2'h0;
    case (f)
      2'h0: k.data = {fs, r.idx, L0.label, L0.bottom_of_stack, xp, 29'h0};
      2'h1: k.data = {ckb_pkg::TYPE_TRI_TAG, fs, LPORT, r.oc, p, d, r.vid, r.sc, 33'h0};
      2'h2: k.data = {ckb_pkg::TYPE_DBL_LABEL, fs, r.idx, L0.label, L0.bottom_of_stack, xp,
                      L1.label, L1.tc, L1.bottom_of_stack, 1'b0, 2'h0};
      default: k.data = {ckb_pkg::TYPE_IDX_TRI_TAG, fs, r.idx, r.oc, r.vid, r.sc, 31'h0};
    endcase
    return k;
  endfunction

  // Puts a row's frame fields on the request port.
  task automatic drv(input ckb_row_t r);
    ckb_pkg::ckb_lse_t l;
    l = L0;
    l.ttl = r.ttl;
    req_second <= r.sec;
    req_tags <= r.tg;
    req_lse0 <= l;
    req_action <= r.act;
  endtask

  // Configures the lookup, sends one request and checks the key taken by the table.
  task automatic run(input ckb_row_t r);
    int          n;
    logic [15:0] c;
    apb(1'b1, ckb_pkg::CTRL_OFS, {24'h0, r.ctrl});
    c = sink_cnt;
    drv(r);
    req_valid <= 1'b1;
    @(posedge pclk);
    req_valid <= 1'b0;
    n = 0;
    while (sink_cnt === c && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (sink_cnt === c) begin
      fails++;
      end_sim();
    end
    chk_key(sink_key, exp_key(r));
    @(posedge pclk);
  endtask

  // Cuts a hung run short.
  initial begin
    #500000;
    fails++;
    end_sim();
  end

  // Main sequence: reset, register checks, table of keys, then the awkward cases.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req_second = 1'b0;
    req_tags = '0;
    req_lse0 = L0;
    req_lse1 = L1;
    req_cl_tci = CL;
    req_action = '0;
    fails = 0;
    total_checks = 0;
    rows = '{
      '{8'h00, 1'b0, tg(16'h0, 16'h0), 15'h0000, 8'h00, 12'h000, 3'h0, 3'h0, 12'h000},
      '{8'h01, 1'b1, tg(16'h0, 16'h0), 15'h0000, 8'h01, 12'h02a, 3'h0, 3'h0, 12'h000},
      '{8'h02, 1'b0, tg(16'h0, 16'h0), 15'h4000, 8'h02, 12'h015, 3'h0, 3'h0, 12'h000},
      '{8'h03, 1'b0, tg(16'h0, 16'h0), 15'h5456, 8'h05, 12'h456, 3'h0, 3'h0, 12'h000},
      '{8'h21, 1'b0, tg(16'h0, 16'h0), 15'h6ff0, 8'hff, 12'h01a, 3'h0, 3'h0, 12'h000},
      '{8'h30, 1'b0, tg(16'h8100, 16'h88a8), 15'h7000, 8'h00, 12'h01a, 3'h1, 3'h4, 12'h123},
      '{8'h10, 1'b0, tg(16'h88a8, 16'h9100), 15'h0000, 8'h00, 12'h000, 3'h4, 3'h5, 12'h123},
      '{8'h14, 1'b0, tg(16'h9200, 16'h9300), 15'h0000, 8'h00, 12'h000, 3'h6, 3'h7, 12'h777},
      '{8'h50, 1'b1, tg(16'h0, 16'h8100), 15'h0000, 8'h00, 12'h000, 3'h0, 3'h0, 12'h000},
      '{8'h80, 1'b1, tg(16'h0, 16'h0), 15'h5001, 8'h01, 12'h001, 3'h0, 3'h0, 12'h000},
      '{8'hc8, 1'b1, tg(16'h1234, 16'h0), 15'h0000, 8'h00, 12'h000, 3'h0, 3'h0, 12'h777}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Every register reads zero after reset.
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk32(rd, 32'h0);
    end
    apb(1'b1, ckb_pkg::PORT_OFS, 32'h0000152a);
    apb(1'b1, ckb_pkg::CUST1_OFS, 32'h00009100);
    apb(1'b1, ckb_pkg::CUST2_OFS, 32'h00009200);
    apb(1'b1, ckb_pkg::CUST3_OFS, 32'h00009300);
    apb(1'b0, ckb_pkg::CUST3_OFS, 32'h0);
    chk32(rd, 32'h00009300);
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // Two requests on consecutive edges give two keys, the last one intact.
    b = rows[3];
    apb(1'b1, ckb_pkg::CTRL_OFS, {24'h0, b.ctrl});
    drv(b);
    req_valid <= 1'b1;
    @(posedge pclk);
    b.ttl = 8'h01;
    drv(b);
    @(posedge pclk);
    req_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk32({16'h0, sink_cnt}, 32'h0000000d);
    chk_key(sink_key, exp_key(b));
    @(posedge pclk);
    // Issued-key count is read-only.
    apb(1'b1, ckb_pkg::STATUS_OFS, 32'hffffffff);
    apb(1'b0, ckb_pkg::STATUS_OFS, 32'h0);
    chk32(rd, 32'h0000000d);
    chk32({31'h0, er}, 32'h0);
    // An unmapped word reads zero with an error.
    apb(1'b0, 8'h18, 32'h0);
    chk32(rd, 32'h0);
    chk32({31'h0, er}, 32'h1);
    // A reset in mid-run clears the key and the settings.
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk_key(key_out, '0);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ckb_pkg::CTRL_OFS, 32'h0);
    chk32(rd, 32'h0);
    end_sim();
  end
endmodule // ckb_key_builder_tb
